// file: hw/fbcp_protect.sv
// flash and eeprom code protection: lock bits, table access checks and programmer gating
//
// Summary of operation
// - program memory split into a 512-byte boot block plus four binary blocks
// - boot 0-1FF, block0 to 7FF, block1 to FFF, block2 to 17FF, block3 to 1FFF
// - each block owns external, table-write and outside-read lock bits
// - cpu table reads and writes reach any program address, subject to locks
// - table reads of the identification address return the device identity word
// - configuration bytes are readable and writable by cpu table accesses
// - external lock blocks only programmer reads and writes, never the cpu
// - table-write lock at 0 suppresses cpu table writes into that block
// - outside-read lock at 0 still lets reads from inside the block through
// - outside-read lock at 0 makes reads from other blocks return zeros
// - lock bits only go from 1 to 0 on writes
// - lock bits return to 1 only by chip erase or block erase
// - eeprom external lock refuses programmer reads and writes of eeprom
// - eeprom write lock refuses programmer eeprom writes, reads still allowed
// - cpu eeprom reads and writes always proceed
// - config write lock guards config bytes and is cpu read-only
`timescale 1ns/1ps
`include "fbcp_defs.svh"

module fbcp_protect #(
	parameter bit          HAS_UPPER = 1'b1,
	parameter logic [15:0] DEVICE_ID = 16'h5aa5   // arbitrary value
)(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// cpu table and eeprom port
	input  wire logic                   cpu_req,
	input  wire logic                   cpu_we,
	input  wire logic                   cpu_ee,
	input  wire logic [21:0]            cpu_addr,
	input  wire logic [21:0]            cpu_pc,
	input  wire logic [7:0]             cpu_wdata,
	output logic                        cpu_ack_q,
	output logic                        cpu_refused_q,
	output logic      [7:0]             cpu_rdata_q,
	// programmer command port
	input  wire logic                   pgm_req,
	input  wire fbcp_pkg::fbcp_cmd_t    pgm_cmd,
	input  wire logic                   pgm_ee,
	input  wire logic [21:0]            pgm_addr,
	input  wire logic [7:0]             pgm_wdata,
	output logic                        pgm_ack_q,
	output logic                        pgm_refused_q,
	output logic      [7:0]             pgm_rdata_q,
	// program flash array
	output logic      [21:0]            fl_addr,
	output logic      [7:0]             fl_wdata,
	output logic                        fl_rd,
	output logic                        fl_wr,
	output logic                        fl_chip_erase,
	output logic                        fl_block_erase,
	output logic      [2:0]             fl_block_sel,
	input  wire logic [7:0]             fl_rdata,
	// data eeprom array
	output logic      [21:0]            ee_addr,
	output logic      [7:0]             ee_wdata,
	output logic                        ee_rd,
	output logic                        ee_wr,
	input  wire logic [7:0]             ee_rdata
);

	// ****************************************************************
	// request capture
	// ****************************************************************
	fbcp_pkg::fbcp_state_t state_q;
	fbcp_pkg::fbcp_cmd_t   cmd_q;
	logic                  from_pgm_q, ee_q, take, take_cpu;
	logic [21:0]           addr_q, pc_q;
	logic [7:0]            wdata_q;

	// cpu wins a tie; the programmer simply keeps its request up
	assign take     = (state_q == fbcp_pkg::FBCP_ST_IDLE) & (cpu_req | pgm_req);
	assign take_cpu = cpu_req;

	// sequencer: idle, one access cycle, one answer cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_q <= fbcp_pkg::FBCP_ST_IDLE;
		else
			case (state_q)
				fbcp_pkg::FBCP_ST_IDLE:   state_q <= take ? fbcp_pkg::FBCP_ST_ACCESS : fbcp_pkg::FBCP_ST_IDLE;
				fbcp_pkg::FBCP_ST_ACCESS: state_q <= fbcp_pkg::FBCP_ST_DONE;
				fbcp_pkg::FBCP_ST_DONE:   state_q <= fbcp_pkg::FBCP_ST_IDLE;
				default:                  state_q <= fbcp_pkg::FBCP_ST_IDLE;
			endcase
	end

	// the cpu path can only encode read or write, so it never erases
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cmd_q      <= fbcp_pkg::FBCP_CMD_READ;
			from_pgm_q <= 1'b0;
			ee_q       <= 1'b0;
			addr_q     <= '0;
			pc_q       <= '0;
			wdata_q    <= `FBCP_ZERO_BYTE;
		end
		else if (take)
		begin
			cmd_q      <= take_cpu ? (cpu_we ? fbcp_pkg::FBCP_CMD_WRITE : fbcp_pkg::FBCP_CMD_READ) : pgm_cmd;
			from_pgm_q <= !take_cpu;
			ee_q       <= take_cpu ? cpu_ee : pgm_ee;
			addr_q     <= take_cpu ? cpu_addr : pgm_addr;
			pc_q       <= cpu_pc;
			wdata_q    <= take_cpu ? cpu_wdata : pgm_wdata;
		end
	end

	// ****************************************************************
	// lock bits (index 0 boot, 1..4 blocks 0..3)
	// ****************************************************************
	logic [4:0] ext_lock_q, wr_lock_q, rd_lock_q;
	logic       ee_lock_q, ee_wr_lock_q, cfg_wr_lock_q;
	logic [4:0] ext_lock_d, wr_lock_d, rd_lock_d;
	logic       ee_lock_d, ee_wr_lock_d, cfg_wr_lock_d;

	// ****************************************************************
	// address decode and permission checks
	// ****************************************************************
	logic [2:0] blk, pc_blk;
	logic       blk_impl, pc_impl;

	fbcp_block_map #(.HAS_UPPER(HAS_UPPER)) u_map_addr (.addr(addr_q), .idx(blk), .impl(blk_impl));

	fbcp_block_map #(.HAS_UPPER(HAS_UPPER)) u_map_pc (.addr(pc_q), .idx(pc_blk), .impl(pc_impl));

	logic acc, rd_op, wr_op, is_cfg, is_id, same_blk;
	logic cpu_prog_ok, prog_ok, ee_ok, cfg_wr_ok, cfg_wr, denied;

	assign acc      = state_q == fbcp_pkg::FBCP_ST_ACCESS;
	assign rd_op    = cmd_q == fbcp_pkg::FBCP_CMD_READ;
	assign wr_op    = cmd_q == fbcp_pkg::FBCP_CMD_WRITE;
	assign is_cfg   = (addr_q >= `FBCP_CFG_EXT_LO) & (addr_q <= `FBCP_CFG_RD_HI);
	assign is_id    = (addr_q == `FBCP_ID_LO) | (addr_q == `FBCP_ID_HI);
	assign same_blk = pc_impl & (pc_blk == blk);

	// cpu ignores the external lock; read lock spares code running inside the block
	assign cpu_prog_ok = rd_op ? (rd_lock_q[blk] | same_blk) : wr_lock_q[blk];
	assign prog_ok     = from_pgm_q ? ext_lock_q[blk] : cpu_prog_ok;
	assign ee_ok       = !from_pgm_q | (ee_lock_q & (rd_op | ee_wr_lock_q));
	assign cfg_wr_ok   = from_pgm_q | cfg_wr_lock_q;
	assign cfg_wr      = acc & !ee_q & wr_op & is_cfg & cfg_wr_ok;
	assign denied      = ee_q ? !ee_ok : ((blk_impl & !prog_ok) | (is_cfg & wr_op & !cfg_wr_ok));

	// array strobes last exactly the access cycle; a 1 lock bit never gates
	assign fl_rd          = acc & !ee_q & rd_op & blk_impl & prog_ok;
	assign fl_wr          = acc & !ee_q & wr_op & blk_impl & prog_ok;
	assign ee_rd          = acc & ee_q & rd_op & ee_ok;
	assign ee_wr          = acc & ee_q & wr_op & ee_ok;
	assign fl_chip_erase  = acc & from_pgm_q & (cmd_q == fbcp_pkg::FBCP_CMD_CHIP_ERASE);
	assign fl_block_erase = acc & from_pgm_q & (cmd_q == fbcp_pkg::FBCP_CMD_BLOCK_ERASE);
	assign fl_block_sel   = wdata_q[2:0];
	assign fl_addr        = addr_q;
	assign fl_wdata       = wdata_q;
	assign ee_addr        = addr_q;
	assign ee_wdata       = wdata_q;

	// ****************************************************************
	// read data selection
	// ****************************************************************
	logic [7:0] cfg_byte, id_byte, rdata_d;

	// unused configuration bits read as zero
	assign cfg_byte =
		(addr_q == `FBCP_CFG_EXT_LO) ? {4'h0, ext_lock_q[4:1]} :
		(addr_q == `FBCP_CFG_EXT_HI) ? ((8'(ee_lock_q) << `FBCP_EE_EXT_BIT) |
		                                (8'(ext_lock_q[`FBCP_IDX_BOOT]) << `FBCP_BOOT_EXT_BIT)) :
		(addr_q == `FBCP_CFG_WR_LO)  ? {4'h0, wr_lock_q[4:1]} :
		(addr_q == `FBCP_CFG_WR_HI)  ? ((8'(ee_wr_lock_q) << `FBCP_EE_WR_BIT) |
		                                (8'(wr_lock_q[`FBCP_IDX_BOOT]) << `FBCP_BOOT_WR_BIT) |
		                                (8'(cfg_wr_lock_q) << `FBCP_CFG_WR_BIT)) :
		(addr_q == `FBCP_CFG_RD_LO)  ? {4'h0, rd_lock_q[4:1]} :
		                               (8'(rd_lock_q[`FBCP_IDX_BOOT]) << `FBCP_BOOT_RD_BIT);
	assign id_byte  = (addr_q == `FBCP_ID_LO) ? DEVICE_ID[7:0] : DEVICE_ID[15:8];

	// denied and unimplemented reads both come back as zeros
	assign rdata_d = ee_q              ? (ee_ok ? ee_rdata : `FBCP_ZERO_BYTE) :
	                 is_cfg            ? cfg_byte :
	                 is_id             ? id_byte :
	                 (blk_impl & prog_ok) ? fl_rdata : `FBCP_ZERO_BYTE;

	// ****************************************************************
	// lock bit update
	// ****************************************************************
	// writes can only clear bits; erase is the sole way back to 1
	always_comb
	begin
		ext_lock_d    = ext_lock_q;
		wr_lock_d     = wr_lock_q;
		rd_lock_d     = rd_lock_q;
		ee_lock_d     = ee_lock_q;
		ee_wr_lock_d  = ee_wr_lock_q;
		cfg_wr_lock_d = cfg_wr_lock_q;
		if (fl_chip_erase)
		begin
			ext_lock_d    = `FBCP_LOCKS_ERASED;
			wr_lock_d     = `FBCP_LOCKS_ERASED;
			rd_lock_d     = `FBCP_LOCKS_ERASED;
			ee_lock_d     = `FBCP_BIT_ERASED;
			ee_wr_lock_d  = `FBCP_BIT_ERASED;
			cfg_wr_lock_d = `FBCP_BIT_ERASED;
		end
		else if (fl_block_erase && fl_block_sel <= `FBCP_IDX_BLK3)
		begin
			ext_lock_d[fl_block_sel] = `FBCP_BIT_ERASED;
			wr_lock_d[fl_block_sel]  = `FBCP_BIT_ERASED;
			rd_lock_d[fl_block_sel]  = `FBCP_BIT_ERASED;
		end
		else if (cfg_wr)
		begin
			case (addr_q)
				`FBCP_CFG_EXT_LO: ext_lock_d[4:1] = ext_lock_q[4:1] & wdata_q[3:0];
				`FBCP_CFG_EXT_HI:
				begin
					ext_lock_d[`FBCP_IDX_BOOT] = ext_lock_q[`FBCP_IDX_BOOT] & wdata_q[`FBCP_BOOT_EXT_BIT];
					ee_lock_d                  = ee_lock_q & wdata_q[`FBCP_EE_EXT_BIT];
				end
				`FBCP_CFG_WR_LO: wr_lock_d[4:1] = wr_lock_q[4:1] & wdata_q[3:0];
				`FBCP_CFG_WR_HI:
				begin
					wr_lock_d[`FBCP_IDX_BOOT] = wr_lock_q[`FBCP_IDX_BOOT] & wdata_q[`FBCP_BOOT_WR_BIT];
					ee_wr_lock_d              = ee_wr_lock_q & wdata_q[`FBCP_EE_WR_BIT];
					if (from_pgm_q)
						cfg_wr_lock_d = cfg_wr_lock_q & wdata_q[`FBCP_CFG_WR_BIT];
				end
				`FBCP_CFG_RD_LO: rd_lock_d[4:1] = rd_lock_q[4:1] & wdata_q[3:0];
				`FBCP_CFG_RD_HI: rd_lock_d[`FBCP_IDX_BOOT] = rd_lock_q[`FBCP_IDX_BOOT] & wdata_q[`FBCP_BOOT_RD_BIT];
				default: ;
			endcase
		end
	end

	// lock storage stands in for nonvolatile cells; reset shows the erased state
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ext_lock_q    <= `FBCP_LOCKS_ERASED;
			wr_lock_q     <= `FBCP_LOCKS_ERASED;
			rd_lock_q     <= `FBCP_LOCKS_ERASED;
			ee_lock_q     <= `FBCP_BIT_ERASED;
			ee_wr_lock_q  <= `FBCP_BIT_ERASED;
			cfg_wr_lock_q <= `FBCP_BIT_ERASED;
		end
		else
		begin
			ext_lock_q    <= ext_lock_d;
			wr_lock_q     <= wr_lock_d;
			rd_lock_q     <= rd_lock_d;
			ee_lock_q     <= ee_lock_d;
			ee_wr_lock_q  <= ee_wr_lock_d;
			cfg_wr_lock_q <= cfg_wr_lock_d;
		end
	end

	// ****************************************************************
	// answers
	// ****************************************************************
	// answer registers hold data until the next answer to the same party
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cpu_ack_q     <= 1'b0;
			cpu_refused_q <= 1'b0;
			cpu_rdata_q   <= `FBCP_ZERO_BYTE;
			pgm_ack_q     <= 1'b0;
			pgm_refused_q <= 1'b0;
			pgm_rdata_q   <= `FBCP_ZERO_BYTE;
		end
		else
		begin
			cpu_ack_q <= acc & !from_pgm_q;
			pgm_ack_q <= acc & from_pgm_q;
			if (acc && !from_pgm_q)
			begin
				cpu_refused_q <= denied;
				cpu_rdata_q   <= rd_op ? rdata_d : `FBCP_ZERO_BYTE;
			end
			if (acc && from_pgm_q)
			begin
				pgm_refused_q <= denied;
				pgm_rdata_q   <= rd_op ? rdata_d : `FBCP_ZERO_BYTE;
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_cpu_take;
		(state_q == fbcp_pkg::FBCP_ST_IDLE) && cpu_req;
	endsequence
	sequence s_cpu_answer;
		##1 (acc && !from_pgm_q) ##1 cpu_ack_q;
	endsequence

	a_cpu_answer_time: assert property (s_cpu_take |-> s_cpu_answer)
		else $error("cpu request not answered two cycles after it was taken");
	a_write_lock_gate: assert property (fl_wr && !from_pgm_q |-> wr_lock_q[blk])
		else $error("cpu table write reached a write-locked block");
	a_outside_read_zero: assert property (acc && !from_pgm_q && rd_op && !ee_q && blk_impl
		&& !rd_lock_q[blk] && !same_blk |=> cpu_rdata_q == `FBCP_ZERO_BYTE && cpu_refused_q)
		else $error("outside table read of a read-locked block returned data");
	a_inside_read_pass: assert property (acc && !from_pgm_q && rd_op && !ee_q && blk_impl
		&& same_blk |=> cpu_rdata_q == $past(fl_rdata))
		else $error("inside table read did not return stored data");
	a_ext_lock_gate: assert property ((fl_rd || fl_wr) && from_pgm_q |-> ext_lock_q[blk])
		else $error("programmer reached an externally locked block");
	a_ee_lock_gate: assert property ((ee_rd || ee_wr) && from_pgm_q |-> ee_lock_q && (ee_rd || ee_wr_lock_q))
		else $error("programmer eeprom access passed an active lock");
	a_ee_cpu_free: assert property (acc && !from_pgm_q && ee_q |-> ee_rd || ee_wr)
		else $error("cpu eeprom access was blocked");
	a_lock_one_way: assert property (!$past(fl_chip_erase) && !$past(fl_block_erase)
		|-> (ext_lock_q & ~$past(ext_lock_q)) == 5'h00 && (wr_lock_q & ~$past(wr_lock_q)) == 5'h00)
		else $error("lock bit rose without an erase");
	a_chip_erase_ones: assert property (fl_chip_erase |=> rd_lock_q == `FBCP_LOCKS_ERASED
		&& ext_lock_q == `FBCP_LOCKS_ERASED && cfg_wr_lock_q)
		else $error("chip erase did not restore lock bits");
	a_cfg_lock_hold: assert property (cfg_wr_lock_q == 1'b0 && acc && !from_pgm_q && wr_op && is_cfg
		|=> $stable(wr_lock_q) && $stable(rd_lock_q) && $stable(ext_lock_q))
		else $error("cpu changed write-protected configuration");

endmodule

// file: hw/fbcp_defs.svh
// address map, field positions and reset values for the flash block code protection logic
`ifndef FBCP_DEFS_SVH
`define FBCP_DEFS_SVH

// program memory block limits (byte addresses, inclusive)
`define FBCP_BOOT_END      22'h00_01ff
`define FBCP_BLK0_END      22'h00_07ff
`define FBCP_BLK1_END      22'h00_0fff
`define FBCP_BLK2_END      22'h00_17ff
`define FBCP_BLK3_END      22'h00_1fff

// configuration byte locations
`define FBCP_CFG_EXT_LO    22'h30_0008
`define FBCP_CFG_EXT_HI    22'h30_0009
`define FBCP_CFG_WR_LO     22'h30_000a
`define FBCP_CFG_WR_HI     22'h30_000b
`define FBCP_CFG_RD_LO     22'h30_000c
`define FBCP_CFG_RD_HI     22'h30_000d

// identification word locations
`define FBCP_ID_LO         22'h3f_fffe
`define FBCP_ID_HI         22'h3f_ffff

// block indices into the five-bit lock vectors
`define FBCP_IDX_BOOT      3'h0
`define FBCP_IDX_BLK0      3'h1
`define FBCP_IDX_BLK1      3'h2
`define FBCP_IDX_BLK2      3'h3
`define FBCP_IDX_BLK3      3'h4
`define FBCP_IDX_NONE      3'h7

// bit positions inside the high configuration bytes
`define FBCP_EE_EXT_BIT    3'h7
`define FBCP_BOOT_EXT_BIT  3'h6
`define FBCP_EE_WR_BIT     3'h7
`define FBCP_BOOT_WR_BIT   3'h6
`define FBCP_CFG_WR_BIT    3'h5
`define FBCP_BOOT_RD_BIT   3'h6

// erased (unprotected) state of the lock bits
`define FBCP_LOCKS_ERASED  5'h1f
`define FBCP_BIT_ERASED    1'h1
`define FBCP_ZERO_BYTE     8'h00

`endif

// file: hw/fbcp_pkg.sv
// types shared by the flash block code protection logic
package fbcp_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		FBCP_ST_IDLE,
		FBCP_ST_ACCESS,
		FBCP_ST_DONE
	} fbcp_state_t;

	// programmer commands
	typedef enum logic [1:0] {
		FBCP_CMD_READ,
		FBCP_CMD_WRITE,
		FBCP_CMD_CHIP_ERASE,
		FBCP_CMD_BLOCK_ERASE
	} fbcp_cmd_t;

endpackage

// file: hw/fbcp_block_map.sv
// maps a program memory byte address onto its protection block
`timescale 1ns/1ps
`include "fbcp_defs.svh"

module fbcp_block_map #(
	parameter bit HAS_UPPER = 1'b1
)(
	// address in
	input  wire logic [21:0] addr,
	// block out
	output logic      [2:0]  idx,
	output logic             impl
);

	// boundary compares
	logic in_boot;
	logic in_b0;
	logic in_b1;
	logic in_b2;
	logic in_b3;

	assign in_boot = addr <= `FBCP_BOOT_END;
	assign in_b0   = addr <= `FBCP_BLK0_END;
	assign in_b1   = addr <= `FBCP_BLK1_END;
	assign in_b2   = addr <= `FBCP_BLK2_END;
	assign in_b3   = addr <= `FBCP_BLK3_END;

	// upper two blocks exist only on the larger memory variant
	assign impl = in_b1 | (HAS_UPPER & in_b3);
	assign idx  = in_boot ? `FBCP_IDX_BOOT :
	              in_b0   ? `FBCP_IDX_BLK0 :
	              in_b1   ? `FBCP_IDX_BLK1 :
	              in_b2   ? `FBCP_IDX_BLK2 :
	              in_b3   ? `FBCP_IDX_BLK3 : `FBCP_IDX_NONE;

endmodule

// file: testbench/fbcp_array_model.sv
// behavioural program flash and data eeprom arrays facing the protection logic
`timescale 1ns/1ps

module fbcp_array_model (
	// clock
	input  wire logic        mclk,
	// program flash side
	input  wire logic [21:0] fl_addr,
	input  wire logic [7:0]  fl_wdata,
	input  wire logic        fl_rd,
	input  wire logic        fl_wr,
	input  wire logic        fl_chip_erase,
	input  wire logic        fl_block_erase,
	input  wire logic [2:0]  fl_block_sel,
	output logic      [7:0]  fl_rdata,
	// data eeprom side
	input  wire logic [21:0] ee_addr,
	input  wire logic [7:0]  ee_wdata,
	input  wire logic        ee_rd,
	input  wire logic        ee_wr,
	output logic      [7:0]  ee_rdata
);
	logic [7:0] flash_q [0:8191];
	logic [7:0] eeprom_q [0:255];

	// block index of a flash byte, boot block first
	function automatic logic [2:0] blk_of(input int i);
		return (i < 512) ? 3'h0 : (i < 2048) ? 3'h1 : (i < 4096) ? 3'h2 : (i < 6144) ? 3'h3 : 3'h4;
	endfunction

	// inverted address start pattern, so only bytes whose low address byte is FF start out as zero
	initial
	begin
		for (int i = 0; i < 8192; i++)
			flash_q[i] = ~i[7:0];
	end

	// outside a read strobe the lines show the inverse, so stale data is never mistaken for a read
	assign fl_rdata = fl_rd ? flash_q[fl_addr[12:0]] : ~flash_q[fl_addr[12:0]];
	assign ee_rdata = ee_rd ? eeprom_q[ee_addr[7:0]] : ~eeprom_q[ee_addr[7:0]];

	// array updates on the strobes; erase fills the cells with the erased value
	always @(posedge mclk)
	begin
		if (fl_wr)
			flash_q[fl_addr[12:0]] <= fl_wdata;
		if (ee_wr)
			eeprom_q[ee_addr[7:0]] <= ee_wdata;
		for (int i = 0; i < 8192; i++)
			if (fl_chip_erase || (fl_block_erase && blk_of(i) == fl_block_sel))
				flash_q[i] <= 8'hff;
	end
endmodule

// file: testbench/test_flash_block_code_protection.sv
// self-checking bench for the flash block code protection logic
`timescale 1ns/1ps

module test_flash_block_code_protection;
	localparam logic [15:0] ID_WORD = 16'hc3e1; // arbitrary value

	// stimulus
	logic                mclk = 1'b0;
	logic                rst = 1'b1;
	logic                cpu_req = 1'b0;
	logic                cpu_we = 1'b0;
	logic                cpu_ee = 1'b0;
	logic [21:0]         cpu_addr = 22'h00_0000;
	logic [21:0]         cpu_pc = 22'h00_0000;
	logic [7:0]          cpu_wdata = 8'h00;
	logic                pgm_req = 1'b0;
	fbcp_pkg::fbcp_cmd_t pgm_cmd = fbcp_pkg::FBCP_CMD_READ;
	logic                pgm_ee = 1'b0;
	logic [21:0]         pgm_addr = 22'h00_0000;
	logic [7:0]          pgm_wdata = 8'h00;
	// responses and array wires
	logic                cpu_ack_q, cpu_refused_q, pgm_ack_q, pgm_refused_q;
	logic [7:0]          cpu_rdata_q, pgm_rdata_q, fl_wdata, fl_rdata, ee_wdata, ee_rdata;
	logic [21:0]         fl_addr, ee_addr;
	logic                fl_rd, fl_wr, fl_chip_erase, fl_block_erase, ee_rd, ee_wr;
	logic [2:0]          fl_block_sel;
	int                  err_count = 0;
	int                  checks = 0;
	logic [21:0]         bnd [9] = '{22'h00_01ff, 22'h00_0200, 22'h00_07ff, 22'h00_0800, 22'h00_0fff,
		22'h00_1000, 22'h00_17ff, 22'h00_1800, 22'h00_1fff};

	always #50 mclk = ~mclk;

	fbcp_protect #(.HAS_UPPER(1'b1), .DEVICE_ID(ID_WORD)) dut (.mclk(mclk), .rst(rst),
		.cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_ee(cpu_ee), .cpu_addr(cpu_addr), .cpu_pc(cpu_pc),
		.cpu_wdata(cpu_wdata), .cpu_ack_q(cpu_ack_q), .cpu_refused_q(cpu_refused_q), .cpu_rdata_q(cpu_rdata_q),
		.pgm_req(pgm_req), .pgm_cmd(pgm_cmd), .pgm_ee(pgm_ee), .pgm_addr(pgm_addr), .pgm_wdata(pgm_wdata),
		.pgm_ack_q(pgm_ack_q), .pgm_refused_q(pgm_refused_q), .pgm_rdata_q(pgm_rdata_q),
		.fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rd(fl_rd), .fl_wr(fl_wr), .fl_chip_erase(fl_chip_erase),
		.fl_block_erase(fl_block_erase), .fl_block_sel(fl_block_sel), .fl_rdata(fl_rdata),
		.ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rd(ee_rd), .ee_wr(ee_wr), .ee_rdata(ee_rdata));

	fbcp_array_model arrays (.mclk(mclk), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rd(fl_rd), .fl_wr(fl_wr),
		.fl_chip_erase(fl_chip_erase), .fl_block_erase(fl_block_erase), .fl_block_sel(fl_block_sel),
		.fl_rdata(fl_rdata), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rd(ee_rd), .ee_wr(ee_wr),
		.ee_rdata(ee_rdata));

	// verdict and end of run
	task automatic tally_and_finish;
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one transfer on either port; request held until the ack is sampled, answer taken at that edge
	// erase commands exist only on the programmer port, the cpu port cannot start one
	task automatic xfer(input logic pgm, input fbcp_pkg::fbcp_cmd_t cmd, input logic ee, input logic [21:0] a,
		input logic [21:0] pc, input logic [7:0] wd, input logic [7:0] ed, input logic er);
		int n;
		logic ack, rf;
		logic [7:0] rd;
		@(posedge mclk);
		if (pgm)
		begin
			pgm_req <= 1'b1;
			pgm_cmd <= cmd;
			pgm_ee <= ee;
			pgm_addr <= a;
			pgm_wdata <= wd;
		end
		else
		begin
			cpu_req <= 1'b1;
			cpu_we <= (cmd == fbcp_pkg::FBCP_CMD_WRITE);
			cpu_ee <= ee;
			cpu_addr <= a;
			cpu_pc <= pc;
			cpu_wdata <= wd;
		end
		n = 0;
		ack = 1'b0;
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			n++;
			ack = pgm ? pgm_ack_q : cpu_ack_q;
		end
		rd = pgm ? pgm_rdata_q : cpu_rdata_q;
		rf = pgm ? pgm_refused_q : cpu_refused_q;
		pgm_req <= 1'b0;
		cpu_req <= 1'b0;
		checks++;
		if (ack !== 1'b1 || rd !== ed || (er !== 1'bx && rf !== er))
		begin
			err_count++;
			$display("Error at %0t: addr %h ack %b data %h/%h refused %b/%b", $time, a, ack, rd, ed, rf, er);
		end
	endtask

	// short forms for the common cases
	task automatic cw(input logic [21:0] a, input logic [7:0] wd, input logic er);
		xfer(1'b0, fbcp_pkg::FBCP_CMD_WRITE, 1'b0, a, 22'h00_0000, wd, 8'h00, er);
	endtask
	task automatic cr(input logic [21:0] a, input logic [21:0] pc, input logic [7:0] ed, input logic er);
		xfer(1'b0, fbcp_pkg::FBCP_CMD_READ, 1'b0, a, pc, 8'h00, ed, er);
	endtask
	task automatic cfg_defaults;
		logic [7:0] exp [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
		for (int i = 0; i < 6; i++)
			cr(22'h30_0008 + 22'(i), 22'h00_0000, exp[i], 1'b0);
	endtask

	// hang guard, far beyond the few hundred cycles the sequence needs
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		cfg_defaults();
		cr(22'h3f_fffe, 22'h00_0000, ID_WORD[7:0], 1'b0);
		cr(22'h3f_ffff, 22'h00_0000, ID_WORD[15:8], 1'b0);
		foreach (bnd[i]) cw(bnd[i], bnd[i][7:0] ^ 8'h5a, 1'b0);
		foreach (bnd[i]) cr(bnd[i], bnd[i], bnd[i][7:0] ^ 8'h5a, 1'b0);
		cr(22'h00_2000, 22'h00_0000, 8'h00, 1'b0);
		// table-write lock on block 0, then an attempt to set it back
		cw(22'h30_000a, 8'h0e, 1'b0);
		cw(22'h30_000a, 8'hff, 1'b0);
		cr(22'h30_000a, 22'h00_0000, 8'h0e, 1'b0);
		cw(22'h00_01ff, 8'h11, 1'b0);
		cw(22'h00_0200, 8'h22, 1'b1);
		cw(22'h00_07ff, 8'h22, 1'b1);
		cw(22'h00_0800, 8'h33, 1'b0);
		cr(22'h00_0200, 22'h00_0200, 8'h5a, 1'b0);
		cr(22'h00_07ff, 22'h00_0200, 8'ha5, 1'b0);
		// outside-read locks on block 1 and boot
		cw(22'h30_000c, 8'h0d, 1'b0);
		cr(22'h00_0fff, 22'h00_0800, 8'ha5, 1'b0);
		cr(22'h00_0fff, 22'h00_07ff, 8'h00, 1'b1);
		cr(22'h00_0fff, 22'h00_1000, 8'h00, 1'b1);
		cw(22'h30_000d, 8'h00, 1'b0);
		cr(22'h00_01ff, 22'h00_0200, 8'h00, 1'b1);
		cr(22'h00_01ff, 22'h00_0000, 8'h11, 1'b0);
		// external lock on block 0 stops only the programmer
		cw(22'h30_0008, 8'h0e, 1'b0);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_READ, 1'b0, 22'h00_0800, 22'h00_0000, 8'h00, 8'h33, 1'b0);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_READ, 1'b0, 22'h00_0200, 22'h00_0000, 8'h00, 8'h00, 1'b1);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_WRITE, 1'b0, 22'h00_0200, 22'h00_0000, 8'h44, 8'h00, 1'b1);
		cr(22'h00_0200, 22'h00_0800, 8'h5a, 1'b0);
		// eeprom locks: write lock, then external lock
		xfer(1'b1, fbcp_pkg::FBCP_CMD_WRITE, 1'b1, 22'h00_0010, 22'h00_0000, 8'h66, 8'h00, 1'b0);
		cw(22'h30_000b, 8'h60, 1'b0);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_WRITE, 1'b1, 22'h00_0010, 22'h00_0000, 8'h99, 8'h00, 1'b1);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_READ, 1'b1, 22'h00_0010, 22'h00_0000, 8'h00, 8'h66, 1'b0);
		cw(22'h30_0009, 8'h40, 1'b0);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_READ, 1'b1, 22'h00_0010, 22'h00_0000, 8'h00, 8'h00, 1'b1);
		xfer(1'b0, fbcp_pkg::FBCP_CMD_WRITE, 1'b1, 22'h00_0010, 22'h00_0000, 8'h88, 8'h00, 1'b0);
		xfer(1'b0, fbcp_pkg::FBCP_CMD_READ, 1'b1, 22'h00_0010, 22'h00_0000, 8'h00, 8'h88, 1'b0);
		// config write lock: cpu cannot clear it, the programmer can, then cpu config writes stop
		cw(22'h30_000b, 8'h00, 1'bx);
		cr(22'h30_000b, 22'h00_0000, 8'h20, 1'b0);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_WRITE, 1'b0, 22'h30_000b, 22'h00_0000, 8'hdf, 8'h00, 1'b0);
		cr(22'h30_000b, 22'h00_0000, 8'h00, 1'b0);
		cw(22'h30_000a, 8'h00, 1'b1);
		cr(22'h30_000a, 22'h00_0000, 8'h0e, 1'b0);
		// block erase of block 0 restores only its bits, then chip erase restores all
		xfer(1'b1, fbcp_pkg::FBCP_CMD_BLOCK_ERASE, 1'b0, 22'h00_0000, 22'h00_0000, 8'h01, 8'h00, 1'b0);
		cr(22'h30_0008, 22'h00_0000, 8'h0f, 1'b0);
		cr(22'h30_000a, 22'h00_0000, 8'h0f, 1'b0);
		cr(22'h30_000c, 22'h00_0000, 8'h0d, 1'b0);
		cr(22'h00_0300, 22'h00_0300, 8'hff, 1'b0);
		xfer(1'b1, fbcp_pkg::FBCP_CMD_CHIP_ERASE, 1'b0, 22'h00_0000, 22'h00_0000, 8'h00, 8'h00, 1'b0);
		cfg_defaults();
		cr(22'h00_0fff, 22'h00_0000, 8'hff, 1'b0);
		tally_and_finish();
	end
endmodule
